//--- hdl/pcs_blank.v
// Leading zero blanking for the BCD display digits
`include "pcs_defines.vh"
module pcs_blank #(
	parameter DIGITS = 7
) (
	// Digits, most significant first in high bits
	input wire [4*DIGITS-1:0] digits,
	input wire [2:0] dp_pos,
	// Per-digit blank mask
	output wire [DIGITS-1:0] blank
);
	wire [DIGITS:0] lead;
	assign lead[DIGITS] = 1'b1;
	genvar i;
	generate
		for (i = DIGITS - 1; i >= 0; i = i - 1) begin : g_dig
			// The digit left of the point always shows
			assign lead[i] = lead[i+1] && (digits[4*i+3:4*i] == 4'h0) && (i > dp_pos);
			assign blank[i] = lead[i];
		end
	endgenerate
endmodule // pcs_blank

//--- hdl/pcs_panel.v
// Front panel control, calibration balance scheduling and indicators
//
// Local design decisions: the placing of the registers and the Avalon-MM slave port.
`include "pcs_defines.vh"
module pcs_panel #(
	parameter DIGITS = 7,
	parameter BAL_CYCLES = `PCS_BAL_PERIOD_S * `PCS_CLK_HZ,
	parameter FLASH_CYCLES = (`PCS_FLASH_PERIOD_MS * (`PCS_CLK_HZ / 1000))
) (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	// Panel buttons, raw pins
	input wire [2:0] btn_func,
	input wire btn_auto,
	input wire [5:0] btn_range,
	input wire btn_ext,
	input wire btn_remote,
	input wire btn_display,
	input wire [3:0] btn_scale,
	input wire btn_track,
	input wire btn_sample,
	input wire btn_filter,
	input wire btn_program,
	// Inhibit command from the interface unit, pin
	input wire panel_input_inhibit,
	// Measurement engine
	input wire meas_done,
	input wire meas_negative,
	input wire meas_overload,
	input wire meas_range_up,
	input wire meas_range_down,
	input wire [4*DIGITS-1:0] meas_digits,
	input wire bal_done,
	output reg meas_start,
	output reg bal_start,
	output reg [1:0] func,
	output reg [2:0] range,
	output reg range_ext,
	output reg [1:0] scale,
	output reg filter_on,
	output reg prog_on,
	// Display
	output reg minus_seg,
	output reg invalid_bars,
	output reg display_flash_off,
	output reg [2:0] dp_pos,
	output reg [4*DIGITS-1:0] disp_digits,
	output wire [DIGITS-1:0] disp_blank,
	// Lamps
	output reg [2:0] lamp_func,
	output reg [5:0] lamp_range,
	output reg lamp_auto,
	output reg lamp_ext,
	output reg lamp_remote,
	output reg lamp_display,
	output reg lamp_track,
	output reg lamp_filter,
	output reg lamp_program,
	// Avalon-MM slave
	input wire [3:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	output reg [31:0] avs_readdata,
	output wire avs_waitrequest
);
	localparam ST_IDLE = 3'b001;
	localparam ST_MEAS = 3'b010;
	localparam ST_BAL = 3'b100;

	// Pin synchronisers, 2 flops each
	localparam NB = 22;
	wire [NB-1:0] pins = {panel_input_inhibit, btn_program, btn_filter, btn_sample, btn_track, btn_scale,
		btn_display, btn_remote, btn_ext, btn_range, btn_auto, btn_func};
	reg [NB-1:0] s1_reg;
	reg [NB-1:0] s2_reg;
	reg [NB-1:0] s3_reg;
	wire [NB-1:0] press = s2_reg & ~s3_reg;
	always @(posedge clk) begin
		if (!rst_n) begin
			s1_reg <= {NB{1'b0}};
			s2_reg <= {NB{1'b0}};
			s3_reg <= {NB{1'b0}};
		end else begin
			s1_reg <= pins;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end
	wire inhibit = s2_reg[21];
	wire [2:0] p_func = press[2:0];
	wire p_auto = press[3];
	wire [5:0] p_range = press[9:4];
	wire p_ext = press[10];
	wire p_remote = press[11];
	wire p_display = press[12];
	wire [3:0] p_scale = press[16:13];
	wire p_track = press[17];
	wire p_sample = press[18];
	wire p_filter = press[19];
	wire p_program = press[20];
	wire p_any = |press[20:0];

	// Software control
	reg [3:0] ctrl_reg;
	reg [31:0] rcmd_reg;
	reg rcmd_stb_reg;
	wire full_len = ctrl_reg[`PCS_CTRL_FULL_LEN];
	wire prog_fit = ctrl_reg[`PCS_CTRL_PROG_FIT];
	wire iface_fit = ctrl_reg[`PCS_CTRL_IFACE_FIT];
	reg remote_reg;
	wire local_ok = !inhibit && !remote_reg && !ctrl_reg[`PCS_CTRL_INHIBIT];
	wire panel_ok = !inhibit && !ctrl_reg[`PCS_CTRL_INHIBIT];

	reg auto_reg;
	reg track_reg;
	reg sel_pending_reg;
	reg sample_req_reg;
	reg [2:0] state_reg;
	reg [31:0] bal_cnt_reg;
	reg bal_req_reg;
	reg [31:0] flash_cnt_reg;
	reg flash_ph_reg;
	reg [2:0] man_rng;
	reg minus_seg_ovl;
	integer k;

	// Manual range from one-hot group, lowest absent on reduced ohms
	always @* begin
		man_rng = range;
		for (k = 0; k < 6; k = k + 1) begin
			if (p_range[k])
				man_rng = k[2:0];
		end
		if (!full_len && func == `PCS_FN_OHM && man_rng == `PCS_RNG_MIN)
			man_rng = 3'd1;
	end

	// Remote command word: [1:0] func, [4:2] range, [5] auto, [7:6] scale, [8] filter, [9] track, [10] sample
	wire [2:0] r_rng = rcmd_reg[4:2];
	wire rem_cmd = rcmd_stb_reg && remote_reg;

	reg [1:0] func_n;
	reg [2:0] range_n;
	reg [1:0] scale_n;
	reg filter_n;
	always @* begin
		func_n = func;
		range_n = range;
		scale_n = scale;
		filter_n = filter_on;
		if (local_ok) begin
			if (p_func[0])
				func_n = `PCS_FN_VDC;
			else if (p_func[1])
				func_n = `PCS_FN_VAC;
			else if (p_func[2])
				func_n = `PCS_FN_OHM;
			if (!auto_reg && |p_range)
				range_n = man_rng;
			if (sel_pending_reg) begin
				if (p_scale[0] || p_scale[1])
					scale_n = p_scale[0] ? `PCS_SCL_3 : 2'd1;
				else if (p_scale[2])
					scale_n = `PCS_SCL_5;
				else if (p_scale[3] && full_len)
					scale_n = `PCS_SCL_6;
			end
			if (p_filter)
				filter_n = !filter_on;
		end else if (rem_cmd) begin
			func_n = rcmd_reg[1:0];
			range_n = (r_rng > `PCS_RNG_MAX) ? `PCS_RNG_MAX : r_rng;
			scale_n = (!full_len && rcmd_reg[7:6] == `PCS_SCL_6) ? `PCS_SCL_5 : rcmd_reg[7:6];
			filter_n = rcmd_reg[8];
		end
		// Autorange step overrides any range chosen this cycle
		if (auto_reg && state_reg == ST_MEAS && meas_done) begin
			if (meas_range_up && range < `PCS_RNG_MAX)
				range_n = range + 3'd1;
			else if (meas_range_down && range > `PCS_RNG_MIN &&
				!(!full_len && func == `PCS_FN_OHM && range == 3'd1))
				range_n = range - 3'd1;
		end
	end

	// Rebalance triggers; longer time means larger scale or filter turned on
	wire longer = (scale_n > scale) || (filter_n && !filter_on);
	wire trig = !remote_reg && ((range_n != range) || (func_n != func) || longer);

	always @(posedge clk) begin
		if (!rst_n) begin
			func <= `PCS_FN_VDC;
			range <= `PCS_RNG_MAX;
			range_ext <= 1'b0;
			scale <= `PCS_SCL_5;
			filter_on <= 1'b0;
			prog_on <= 1'b0;
			auto_reg <= 1'b1;
			track_reg <= 1'b1;
			remote_reg <= 1'b0;
			sel_pending_reg <= 1'b0;
			sample_req_reg <= 1'b0;
		end else begin
			func <= func_n;
			range <= range_n;
			scale <= scale_n;
			filter_on <= filter_n;
			// Clear first, so a request landing in the launch cycle wins
			if (state_reg == ST_IDLE && !track_reg && sample_req_reg && !bal_req_reg && !trig)
				sample_req_reg <= 1'b0;
			if (local_ok) begin
				if (p_auto)
					auto_reg <= !auto_reg;
				if (p_ext && func == `PCS_FN_OHM)
					range_ext <= !range_ext;
				if (p_display)
					sel_pending_reg <= 1'b1;
				else if (sel_pending_reg && |p_scale)
					sel_pending_reg <= 1'b0;
				if (p_track)
					track_reg <= 1'b1;
				else if (p_sample) begin
					track_reg <= 1'b0;
					sample_req_reg <= 1'b1;
				end
				if (p_program && prog_fit)
					prog_on <= !prog_on;
			end else if (rem_cmd) begin
				auto_reg <= rcmd_reg[5];
				track_reg <= rcmd_reg[9];
				if (rcmd_reg[10])
					sample_req_reg <= 1'b1;
			end
			if (func_n != `PCS_FN_OHM)
				range_ext <= 1'b0;
			if (panel_ok && p_remote && iface_fit)
				remote_reg <= !remote_reg;
			if (!iface_fit)
				remote_reg <= 1'b0;
		end
	end

	// Periodic balance timer and pending request
	wire bal_tick = (bal_cnt_reg == BAL_CYCLES - 1);
	always @(posedge clk) begin
		if (!rst_n) begin
			bal_cnt_reg <= 32'h0;
			bal_req_reg <= 1'b0;
		end else begin
			bal_cnt_reg <= (bal_tick || remote_reg) ? 32'h0 : bal_cnt_reg + 32'h1;
			if ((bal_tick && !remote_reg) || trig)
				bal_req_reg <= 1'b1;
			else if (state_reg == ST_IDLE)
				bal_req_reg <= 1'b0;
		end
	end

	// Sequencer: balance has priority over the next reading
	always @(posedge clk) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			meas_start <= 1'b0;
			bal_start <= 1'b0;
		end else begin
			meas_start <= 1'b0;
			bal_start <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					if (bal_req_reg || trig) begin
						bal_start <= 1'b1;
						state_reg <= ST_BAL;
					end else if (track_reg || sample_req_reg) begin
						meas_start <= 1'b1;
						state_reg <= ST_MEAS;
					end
				end
				ST_MEAS: begin
					if (meas_done)
						state_reg <= ST_IDLE;
				end
				ST_BAL: begin
					if (bal_done)
						state_reg <= ST_IDLE;
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// Display update on each completed reading; bars also set on a rebalance trigger unless a reading completes in that cycle, point follows range
	always @(posedge clk) begin
		if (!rst_n) begin
			minus_seg <= 1'b0;
			invalid_bars <= 1'b1;
			disp_digits <= {4*DIGITS{1'b0}};
			dp_pos <= 3'd0;
		end else begin
			if (state_reg == ST_MEAS && meas_done) begin
				minus_seg <= meas_negative;
				invalid_bars <= meas_overload;
				disp_digits <= meas_digits;
			end else if (trig)
				invalid_bars <= 1'b1;
			dp_pos <= range + {2'b00, range_ext};
		end
	end

	// Flash timebase
	always @(posedge clk) begin
		if (!rst_n) begin
			flash_cnt_reg <= 32'h0;
			flash_ph_reg <= 1'b0;
		end else if (flash_cnt_reg == FLASH_CYCLES - 1) begin
			flash_cnt_reg <= 32'h0;
			flash_ph_reg <= !flash_ph_reg;
		end else
			flash_cnt_reg <= flash_cnt_reg + 32'h1;
	end

	// Lamps and overload flash
	always @(posedge clk) begin
		if (!rst_n) begin
			lamp_func <= 3'b000;
			lamp_range <= 6'h00;
			lamp_auto <= 1'b0;
			lamp_ext <= 1'b0;
			lamp_remote <= 1'b0;
			lamp_display <= 1'b0;
			lamp_track <= 1'b0;
			lamp_filter <= 1'b0;
			lamp_program <= 1'b0;
			display_flash_off <= 1'b0;
		end else begin
			lamp_func <= 3'b001 << func;
			lamp_range <= 6'h01 << range;
			lamp_auto <= auto_reg;
			lamp_ext <= range_ext;
			lamp_remote <= remote_reg;
			lamp_display <= sel_pending_reg && flash_ph_reg;
			lamp_track <= track_reg;
			lamp_filter <= filter_on;
			lamp_program <= prog_on;
			display_flash_off <= invalid_bars && minus_seg_ovl && flash_ph_reg;
		end
	end
	always @(posedge clk) begin
		if (!rst_n)
			minus_seg_ovl <= 1'b0;
		else if (state_reg == ST_MEAS && meas_done)
			minus_seg_ovl <= meas_overload;
	end

	pcs_blank #(
		.DIGITS(DIGITS)
	) u_blank (
		.digits(disp_digits),
		.dp_pos(dp_pos),
		.blank(disp_blank)
	);

	// Avalon slave: writes take no wait, reads one wait so read data comes from a register
	reg rd_ack_reg;
	reg [31:0] rd_mux;
	assign avs_waitrequest = avs_read && !rd_ack_reg;
	always @(posedge clk) begin
		if (!rst_n) begin
			ctrl_reg <= `PCS_CTRL_RESET;
			rcmd_reg <= 32'h0;
			rcmd_stb_reg <= 1'b0;
			rd_ack_reg <= 1'b0;
			avs_readdata <= 32'h0;
		end else begin
			rcmd_stb_reg <= 1'b0;
			rd_ack_reg <= avs_read && !rd_ack_reg;
			if (avs_read && !rd_ack_reg)
				avs_readdata <= rd_mux;
			if (avs_write && avs_address == `PCS_ADR_CTRL)
				ctrl_reg <= avs_writedata[3:0];
			if (avs_write && avs_address == `PCS_ADR_REMOTE) begin
				rcmd_reg <= avs_writedata;
				rcmd_stb_reg <= 1'b1;
			end
		end
	end
	always @* begin
		case (avs_address)
			`PCS_ADR_CTRL: rd_mux = {28'h0, ctrl_reg};
			`PCS_ADR_STAT: rd_mux = {13'h0, state_reg, sel_pending_reg, remote_reg, track_reg, auto_reg,
				prog_on, filter_on, range_ext, scale, range, func, inhibit, p_any};
			`PCS_ADR_RESULT: rd_mux = {invalid_bars, minus_seg, 2'h0, disp_digits};
			`PCS_ADR_REMOTE: rd_mux = rcmd_reg;
			default: rd_mux = 32'h0;
		endcase
	end
endmodule // pcs_panel

//--- include/pcs_defines.vh
// Constants for the panel control sequencer
// What this block does
// - Three function buttons pick dc volts, ac volts or resistance; function sets units.
// - Autorange latched picks range itself; released, range follows manual range button.
// - Reduced variant in resistance: lowest range request selects next higher range; a remote command still selects the lowest range.
// - Extension button raises resistance range by exactly one decade.
// - Remote latched accepts remote commands; released returns to local panel control.
// - After display-select, scale buttons pick scale length and paired time; fewer on reduced.
// - Continuous mode starts readings back to back, updating display each reading.
// - Single-shot mode takes exactly one reading per request and holds it.
// - Filter selection lengthens the integration time of each reading.
// - Without processing board, program button presses are ignored.
// - Panel inhibit command blocks every panel button except power, including local.
// - Under local control a rebalance cycle starts periodically from the internal clock.
// - Under local control a range change, manual or automatic, starts rebalance.
// - Under local control a function change starts rebalance.
// - Under local control selecting a longer integration time starts rebalance.
// - Minus segment lights only when the measured quantity is negative.
// - Invalid bars light while result invalid, go off once a valid result shows.
// - Whole display flashes as invalid indication, normally on range overload.
// - Decimal point position follows the current range.
// - Lamps of selected function and active states light steadily.
// - Remote lamp lights under remote control, only when the interface is fitted.
// - Display-select lamp flashes after press, goes off once a scale length is chosen.
// - Power-up defaults to the five-nines scale length.
// - Leading zeros blanked except the zero directly left of the decimal point.
`ifndef PCS_DEFINES_VH
`define PCS_DEFINES_VH
`define PCS_CLK_HZ 100000000
`define PCS_BAL_PERIOD_S 10
`define PCS_FLASH_PERIOD_MS 250
`define PCS_FN_VDC 2'd0
`define PCS_FN_VAC 2'd1
`define PCS_FN_OHM 2'd2
`define PCS_RNG_MIN 3'd0
`define PCS_RNG_MAX 3'd5
`define PCS_SCL_3 2'd0
`define PCS_SCL_5 2'd2
`define PCS_SCL_6 2'd3
`define PCS_ADR_CTRL 4'h0
`define PCS_ADR_STAT 4'h1
`define PCS_ADR_RESULT 4'h2
`define PCS_ADR_REMOTE 4'h3
`define PCS_CTRL_FULL_LEN 0
`define PCS_CTRL_PROG_FIT 1
`define PCS_CTRL_IFACE_FIT 2
`define PCS_CTRL_INHIBIT 3
`define PCS_CTRL_RESET 4'h5
`endif

//--- verification/pcs_operator.sv
// Operator model: panel buttons and the inhibit line
module pcs_operator (
	// Clock
	input wire clk,
	// Buttons
	output wire [2:0] btn_func,
	output wire btn_auto,
	output wire [5:0] btn_range,
	output wire btn_ext,
	output wire btn_remote,
	output wire btn_display,
	output wire [3:0] btn_scale,
	output wire btn_track,
	output wire btn_sample,
	output wire btn_filter,
	output wire btn_program,
	// Interface unit
	output logic panel_input_inhibit = 0
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [20:0] held_reg = 0;
	assign {btn_program, btn_filter, btn_sample, btn_track, btn_scale, btn_display,
		btn_remote, btn_ext, btn_range, btn_auto, btn_func} = held_reg;
	// Held like a finger, long past the input synchroniser
	task press(input integer i);
		@(posedge clk);
		held_reg[i] <= 1'b1;
		repeat (6) @(posedge clk);
		held_reg[i] <= 1'b0;
		repeat (10) @(posedge clk);
	endtask
	task block(input v);
		@(posedge clk);
		panel_input_inhibit <= v;
		repeat (4) @(posedge clk);
	endtask
endmodule // pcs_operator

//--- verification/pcs_panel_assertions.sv
// Port-level property checker for the panel control sequencer
module pcs_panel_assertions #(
	parameter BAL_CYCLES = 200
) (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	// Observed pins
	input wire panel_input_inhibit,
	input wire bal_start,
	input wire [1:0] func,
	input wire [2:0] range,
	input wire range_ext,
	input wire [1:0] scale,
	input wire filter_on,
	input wire [2:0] lamp_func,
	input wire lamp_remote,
	input wire lamp_display
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// Cycles since last balance; slack covers a balance held off by a reading
	integer gap_reg;
	always @(posedge clk) begin
		if (!rst_n || bal_start || lamp_remote)
			gap_reg <= 0;
		else
			gap_reg <= gap_reg + 1;
	end
	AST_FUNC_LAMP: assert property ($stable(func)[*3] |-> lamp_func == (3'd1 << func))
		else $error("function lamp does not match function");
	AST_EXT_OHM: assert property ($stable(func)[*3] |-> !range_ext || func == 2'd2)
		else $error("extension range outside resistance");
	AST_BAL_FUNC: assert property ($changed(func) && !lamp_remote |-> ##[0:16] bal_start)
		else $error("no balance after function change");
	AST_BAL_RANGE: assert property ($changed(range) && !lamp_remote |-> ##[0:16] bal_start)
		else $error("no balance after range change");
	AST_BAL_FILTER: assert property ($rose(filter_on) && !lamp_remote |-> ##[0:16] bal_start)
		else $error("no balance after longer integration");
	AST_BAL_PERIOD: assert property (!lamp_remote |-> gap_reg <= BAL_CYCLES + 40)
		else $error("periodic balance overdue");
	AST_INHIBIT: assert property (panel_input_inhibit[*8] ##0 !lamp_remote
		|-> $stable(func) && $stable(scale) && $stable(filter_on))
		else $error("panel state changed while inhibited");
	AST_SCALE_LAMP: assert property ($changed(scale) && !lamp_remote |-> ##[0:2] !lamp_display)
		else $error("display lamp still on after scale choice");
	cover property ($changed(func));
	cover property ($rose(range_ext));
	cover property ($rose(lamp_remote));
endmodule // pcs_panel_assertions

bind pcs_panel pcs_panel_assertions #(.BAL_CYCLES(BAL_CYCLES)) u_pcs_panel_assertions (.*);

//--- verification/pcs_panel_tb.sv
// Self-checking bench for the panel control sequencer
module pcs_panel_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst_n = 0, panel_input_inhibit, btn_auto, btn_ext, btn_remote, btn_display;
	logic btn_track, btn_sample, btn_filter, btn_program, meas_start, bal_start, range_ext;
	logic meas_done, meas_negative, meas_overload, meas_range_up, meas_range_down;
	logic bal_done, avs_read = 0, avs_write = 0, avs_waitrequest, ovl = 0, hi, lo, ng;
	logic filter_on, prog_on, minus_seg, invalid_bars, display_flash_off, lamp_auto, lamp_ext;
	logic lamp_remote, lamp_display, lamp_track, lamp_filter, lamp_program;
	logic [1:0] func, scale;
	logic [2:0] btn_func, lamp_func, range, dp_pos;
	logic [5:0] btn_range, lamp_range;
	logic [3:0] btn_scale, avs_address, md, bd;
	logic [6:0] disp_blank;
	logic [27:0] meas_digits, disp_digits, dig;
	logic [31:0] avs_writedata, avs_readdata, q, seed = 32'hec5b;
	integer error_cnt = 0, checks_done = 0, i, k, starts = 0;
	pcs_panel #(.BAL_CYCLES(200), .FLASH_CYCLES(8)) u_pcs_panel (.*);
	pcs_operator u_pcs_operator (.*);
	always #5 clk = ~clk;
	function [31:0] xs(input [31:0] s);
		xs = s ^ (s << 13);
		xs = xs ^ (xs >> 17);
		xs = xs ^ (xs << 5);
	endfunction
	function [27:0] bcd(input [31:0] s);
		for (int j = 0; j < 7; j++)
			bcd[4*j+:4] = s[4*j+:4] % 10;
	endfunction
	// Leading zeros blank down to the digit left of the point
	function [6:0] blk(input [27:0] d, input [2:0] p);
		logic l;
		l = 1;
		for (int j = 6; j >= 0; j--) begin
			l = l && d[4*j+:4] == 0 && j > p;
			blk[j] = l;
		end
	endfunction
	// Engine stand-in: fixed latency, fresh random reading each time
	always @(posedge clk) begin
		if (!rst_n) begin
			md <= 0;
			bd <= 0;
		end else begin
			md <= meas_start ? 4'd6 : md - (md != 0);
			bd <= bal_start ? 4'd4 : bd - (bd != 0);
		end
		meas_done <= md == 1;
		bal_done <= bd == 1;
		starts += (meas_start === 1'b1);
		if (md == 1) begin
			seed = xs(seed);
			meas_negative <= seed[0];
			meas_overload <= ovl;
			meas_range_up <= seed[5] && seed[6];
			meas_range_down <= !seed[5] && seed[6];
			meas_digits <= bcd(seed);
		end
	end
	task chk(input [31:0] seen, input [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task close_out;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task bus(input w, input [3:0] a, input [31:0] d);
		integer n;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (avs_waitrequest !== 1'b0) begin
			error_cnt++;
			close_out;
		end
		q = avs_readdata;
		avs_write <= 0;
		avs_read <= 0;
	endtask
	task wait_done;
		integer n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (meas_done !== 1'b1 && n < 2000);
		if (meas_done !== 1'b1) begin
			error_cnt++;
			close_out;
		end
		dig = meas_digits;
		ng = meas_negative;
		repeat (3) @(posedge clk);
	endtask
	task flash_seen(input s);
		hi = 0;
		lo = 0;
		repeat (40) begin
			@(posedge clk);
			hi |= s ? lamp_display : display_flash_off;
			lo |= s ? !lamp_display : !display_flash_off;
		end
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1;
		@(posedge clk);
		chk(scale, 2);
		chk(invalid_bars, 1);
		bus(0, 4'h0, 0);
		chk(q, 5);
		bus(0, 4'h9, 0);
		chk(q, 0);
		for (i = 0; i < 6; i++) begin
			seed = xs(seed);
			k = seed % 3;
			u_pcs_operator.press(k);
			chk(func, k);
			chk(lamp_func, 1 << k);
		end
		u_pcs_operator.press(3);
		chk(lamp_auto, 0);
		for (i = 5; i >= 0; i--) begin
			u_pcs_operator.press(4 + i);
			chk(range, i);
			chk(lamp_range, 1 << i);
		end
		bus(1, 4'h0, 32'h4);
		u_pcs_operator.press(2);
		u_pcs_operator.press(4);
		chk(range, 1);
		u_pcs_operator.press(10);
		chk(range_ext, 1);
		chk(dp_pos, 2);
		chk(lamp_ext, 1);
		bus(1, 4'h0, 32'h5);
		u_pcs_operator.press(12);
		flash_seen(1);
		chk({hi, lo}, 3);
		u_pcs_operator.press(16);
		chk(scale, 3);
		chk(lamp_display, 0);
		u_pcs_operator.press(19);
		chk(filter_on, 1);
		chk(lamp_filter, 1);
		u_pcs_operator.press(20);
		chk(prog_on, 0);
		chk(lamp_program, 0);
		u_pcs_operator.block(1);
		u_pcs_operator.press(0);
		chk(func, 2);
		u_pcs_operator.block(0);
		u_pcs_operator.press(11);
		chk(lamp_remote, 1);
		// Remote word keeps track on, so readings continue afterwards
		bus(1, 4'h3, 32'h28d);
		repeat (4) @(posedge clk);
		chk(func, 1);
		chk(range, 3);
		u_pcs_operator.press(11);
		chk(lamp_remote, 0);
		for (i = 0; i < 4; i++) begin
			wait_done;
			chk(minus_seg, ng);
			chk(invalid_bars, 0);
			chk(disp_digits, dig);
			chk(dp_pos, 3);
			chk(disp_blank, blk(dig, 3));
			chk(lamp_track, 1);
		end
		ovl <= 1;
		wait_done;
		wait_done;
		flash_seen(0);
		chk({hi, lo}, 3);
		chk(invalid_bars, 1);
		ovl <= 0;
		// Second request only, so a reading in flight at the mode switch is not counted
		u_pcs_operator.press(18);
		// Let the first single reading and any balance finish
		repeat (100) @(posedge clk);
		k = starts;
		u_pcs_operator.press(18);
		repeat (200) @(posedge clk);
		chk(starts - k, 1);
		close_out;
	end
endmodule // pcs_panel_tb
